// ### ocr_output_channel_config_regs.sv
// Notes on behaviour
// RL1: Pair A divider ratio is the 8-bit field plus one.
// RL2: Pair B divider ratio is its low-byte field plus one.
// RL3: Channel 3 run mode: off, running, static low, static high.
// RL4: Channel 2 run mode in bits 2:1, same four-way coding.
// RL5: Channel 3 driver: 00/01 low swing, 10 current mode, 11 high swing.
// RL6: Channel 2 driver in bits 4:3 decodes like channel 3.
// RL7: Channel 4 driver: 00/01 low swing, 10 single-ended, 11 host clock.
// RL8: Channel 4 source: 00/11 PLL, 01 primary, 10 secondary input.
// RL9: Channel 4 prescaler: 000 divide 2, 001 divide 3, 111 divide 1.
// RL10: Prescaler is bypassed while the fractional divider is off; out4Cfg.prescaleRatio is 0 from reset until the first enabled edge after it.
// RL11: Bit 9 turns the channel 4 fractional divider on.
// RL12: Bit 8 picks slow edge rate for the single-ended driver.
// RL13: Bit 6 turns on the positive single-ended output.
// RL14: Negative single-ended output only active with positive side on.
// RL15: Channel 4 run mode in bits 2:1, same four-way coding.
// RL16: Pair B supply bit: 0 is 1.8 V, 1 is 2.5/3.3 V.
// RL17: Channel 4 supply bit: 0 is 1.8 V, 1 is 2.5/3.3 V.
// RL18: Supply bits may stay zero at power-up and change later.
// RL19: Software writes zeros to all reserved bits.
// RL20: Software uses only the three defined prescaler codes.
// RL21: Registers are 16 bits and read back their defined fields.
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module ocr_output_channel_config_regs (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic [ocr_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ocr_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [ocr_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [ocr_pkg::RATIO_W-1:0] pairADivRatio,
    output logic [ocr_pkg::RATIO_W-1:0] pairBDivRatio,
    output logic pairBSupplyHigh,
    output ocr_pkg::ocr_chan_s out2Cfg,
    output ocr_pkg::ocr_chan_s out3Cfg,
    output ocr_pkg::ocr_chan4_s out4Cfg
);

    logic [ocr_pkg::REG_W-1:0] regPairADiv;
    logic [ocr_pkg::REG_W-1:0] regPairBDrv;
    logic [ocr_pkg::REG_W-1:0] regPairBDiv;
    logic [ocr_pkg::REG_W-1:0] regOut4Ctl;
    logic [ocr_pkg::REG_W-1:0] wrWord;
    logic wrPairADiv;
    logic wrPairBDrv;
    logic wrPairBDiv;
    logic wrOut4Ctl;
    logic rdValid;

    // Address decode
    logic hitPairADiv;
    logic hitPairBDrv;
    logic hitPairBDiv;
    logic hitOut4Ctl;
    logic hitStatus;
    logic mapped;
    assign hitPairADiv = (paddr == ocr_pkg::ADDR_PAIR_A_DIV);
    assign hitPairBDrv = (paddr == ocr_pkg::ADDR_PAIR_B_DRV);
    assign hitPairBDiv = (paddr == ocr_pkg::ADDR_PAIR_B_DIV);
    assign hitOut4Ctl = (paddr == ocr_pkg::ADDR_OUT4_CTL);
    assign hitStatus = (paddr == ocr_pkg::ADDR_STATUS);
    assign mapped = hitPairADiv | hitPairBDrv | hitPairBDiv | hitOut4Ctl | hitStatus;

    // Data is captured in setup so the access phase answers from flip-flops
    logic capture;
    logic finish;
    logic wrFire;
    assign capture = psel & ~rdValid;
    assign finish = psel & penable & rdValid;
    assign wrFire = clkEn & finish & pwrite & mapped;
    // A frozen block must not complete a transfer
    assign pready = clkEn & rdValid;

    logic [ocr_pkg::REG_W-1:0] laneMask;
    assign laneMask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    // Only the low half carries a register; upper lanes are ignored
    assign wrWord = pwdata[ocr_pkg::REG_W-1:0];
    assign wrPairADiv = wrFire & hitPairADiv;
    assign wrPairBDrv = wrFire & hitPairBDrv;
    assign wrPairBDiv = wrFire & hitPairBDiv;
    assign wrOut4Ctl = wrFire & hitOut4Ctl;

    ocr_cfg_word #(
        .FIELDS(ocr_pkg::MASK_PAIR_A_DIV)
    ) pairADivWord (
        .clk_sys(clk_sys),
        .rst(rst),
        .clkEn(clkEn),
        .wrEn(wrPairADiv),
        .wrData(wrWord),
        .lanes(laneMask),
        .word(regPairADiv)
    ); // RL21

    ocr_cfg_word #(
        .FIELDS(ocr_pkg::MASK_PAIR_B_DRV)
    ) pairBDrvWord (
        .clk_sys(clk_sys),
        .rst(rst),
        .clkEn(clkEn),
        .wrEn(wrPairBDrv),
        .wrData(wrWord),
        .lanes(laneMask),
        .word(regPairBDrv)
    ); // RL21

    ocr_cfg_word #(
        .FIELDS(ocr_pkg::MASK_PAIR_B_DIV)
    ) pairBDivWord (
        .clk_sys(clk_sys),
        .rst(rst),
        .clkEn(clkEn),
        .wrEn(wrPairBDiv),
        .wrData(wrWord),
        .lanes(laneMask),
        .word(regPairBDiv)
    ); // RL21

    ocr_cfg_word #(
        .FIELDS(ocr_pkg::MASK_OUT4_CTL)
    ) out4CtlWord (
        .clk_sys(clk_sys),
        .rst(rst),
        .clkEn(clkEn),
        .wrEn(wrOut4Ctl),
        .wrData(wrWord),
        .lanes(laneMask),
        .word(regOut4Ctl)
    ); // RL21

    // Field extraction
    logic [1:0] out2DrvCode;
    logic [1:0] out3DrvCode;
    logic [1:0] out4DrvCode;
    logic [1:0] out4SrcCode;
    logic [2:0] out4PreCode;
    logic out4FracOn;
    logic out4PosOn;
    logic out4NegReq;
    assign out2DrvCode = regPairBDrv[ocr_pkg::OUT2_DRV_LSB +: 2];
    assign out3DrvCode = regPairBDrv[ocr_pkg::OUT3_DRV_LSB +: 2];
    assign out4DrvCode = regOut4Ctl[ocr_pkg::OUT4_DRV_LSB +: 2];
    assign out4SrcCode = regOut4Ctl[ocr_pkg::OUT4_SRC_LSB +: 2];
    assign out4PreCode = regOut4Ctl[ocr_pkg::OUT4_PRE_LSB +: 3];
    assign out4FracOn = regOut4Ctl[ocr_pkg::OUT4_FRAC_BIT]; // RL11
    assign out4PosOn = regOut4Ctl[ocr_pkg::OUT4_POS_BIT]; // RL13
    assign out4NegReq = regOut4Ctl[ocr_pkg::OUT4_NEG_BIT];

    // Decoded configuration
    ocr_pkg::ocr_drv_e out2Drv;
    ocr_pkg::ocr_drv_e out3Drv;
    ocr_pkg::ocr_drv4_e out4Drv;
    ocr_pkg::ocr_src_e out4Src;
    logic [1:0] out2Kind;
    logic [1:0] out3Kind;
    logic [1:0] out4Kind;
    ocr_drv_code out2Decode (
        .code(out2DrvCode),
        .kind(out2Kind)
    ); // RL6
    ocr_drv_code out3Decode (
        .code(out3DrvCode),
        .kind(out3Kind)
    ); // RL5
    ocr_drv_code out4Decode (
        .code(out4DrvCode),
        .kind(out4Kind)
    ); // RL7
    // Channel 4 names differ but its driver codes rank the same way
    assign out2Drv = ocr_pkg::ocr_drv_e'(out2Kind); // RL6
    assign out3Drv = ocr_pkg::ocr_drv_e'(out3Kind); // RL5
    assign out4Drv = ocr_pkg::ocr_drv4_e'(out4Kind); // RL7
    assign out4Src = (out4SrcCode == ocr_pkg::SRC_CODE_PRI) ? ocr_pkg::SRC_PRIMARY :
        (out4SrcCode == ocr_pkg::SRC_CODE_SEC) ? ocr_pkg::SRC_SECONDARY :
        ocr_pkg::SRC_PLL; // RL8

    // Reserved prescaler codes fall back to divide by one and are flagged while the fractional divider is on
    logic preCodeValid;
    logic [1:0] preRatio;
    assign preCodeValid = (out4PreCode == ocr_pkg::PRE_CODE_DIV2) |
        (out4PreCode == ocr_pkg::PRE_CODE_DIV3) |
        (out4PreCode == ocr_pkg::PRE_CODE_DIV1);
    assign preRatio = ~out4FracOn ? ocr_pkg::RATIO_ONE : // RL10
        (out4PreCode == ocr_pkg::PRE_CODE_DIV2) ? ocr_pkg::RATIO_TWO : // RL9
        (out4PreCode == ocr_pkg::PRE_CODE_DIV3) ? ocr_pkg::RATIO_THREE : // RL9
        ocr_pkg::RATIO_ONE; // RL9

    // Negative side is gated so a lone enable cannot reach the driver
    logic out4NegOn;
    assign out4NegOn = out4NegReq & out4PosOn; // RL14

    ocr_pkg::ocr_chan_s next_out2Cfg;
    ocr_pkg::ocr_chan_s next_out3Cfg;
    ocr_pkg::ocr_chan4_s next_out4Cfg;
    logic [ocr_pkg::RATIO_W-1:0] next_pairADivRatio;
    logic [ocr_pkg::RATIO_W-1:0] next_pairBDivRatio;
    ocr_div_ratio pairARatio (
        .field(regPairADiv[ocr_pkg::DIV_LSB +: ocr_pkg::DIV_W]),
        .ratio(next_pairADivRatio)
    ); // RL1
    ocr_div_ratio pairBRatio (
        .field(regPairBDiv[ocr_pkg::DIV_LSB +: ocr_pkg::DIV_W]),
        .ratio(next_pairBDivRatio)
    ); // RL2
    assign next_out2Cfg.runMode =
        ocr_pkg::ocr_run_e'(regPairBDrv[ocr_pkg::OUT2_RUN_LSB +: 2]); // RL4
    assign next_out2Cfg.driverType = out2Drv;
    assign next_out3Cfg.runMode =
        ocr_pkg::ocr_run_e'(regPairBDrv[ocr_pkg::OUT3_RUN_LSB +: 2]); // RL3
    assign next_out3Cfg.driverType = out3Drv;
    assign next_out4Cfg.runMode =
        ocr_pkg::ocr_run_e'(regOut4Ctl[ocr_pkg::OUT4_RUN_LSB +: 2]); // RL15
    assign next_out4Cfg.driverType = out4Drv;
    assign next_out4Cfg.source = out4Src;
    assign next_out4Cfg.fracOn = out4FracOn; // RL11
    assign next_out4Cfg.prescaleRatio = preRatio;
    assign next_out4Cfg.edgeSlow = regOut4Ctl[ocr_pkg::OUT4_SLEW_BIT]; // RL12
    assign next_out4Cfg.singlePosOn = out4PosOn; // RL13
    assign next_out4Cfg.singleNegOn = out4NegOn;
    assign next_out4Cfg.supplyHigh = regOut4Ctl[ocr_pkg::SUPPLY_BIT]; // RL17

    // Status shows decoded state, not stored bits
    logic [ocr_pkg::REG_W-1:0] statusWord;
    assign statusWord = {12'h000, out4FracOn & ~preCodeValid, out4NegReq & ~out4PosOn, preRatio};

    logic [ocr_pkg::DATA_W-1:0] rdMux;
    assign rdMux = hitPairADiv ? {16'h0000, regPairADiv} :
        hitPairBDrv ? {16'h0000, regPairBDrv} :
        hitPairBDiv ? {16'h0000, regPairBDiv} :
        hitOut4Ctl ? {16'h0000, regOut4Ctl} :
        hitStatus ? {16'h0000, statusWord} :
        32'h00000000;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdValid <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (clkEn) begin
            if (capture) begin
                rdValid <= 1'b1;
                prdata <= pwrite ? 32'h00000000 : rdMux;
                pslverr <= ~mapped;
            end else if (finish) begin
                rdValid <= 1'b0;
            end
        end
    end

    // Decoded outputs lag the register by one enabled edge
    ocr_out_stage #(
        .W(ocr_pkg::RATIO_W),
        .INIT(ocr_pkg::DIV_OFFSET)
    ) pairAStage (
        .clk_sys(clk_sys),
        .rst(rst),
        .clkEn(clkEn),
        .d(next_pairADivRatio),
        .q(pairADivRatio)
    ); // RL1

    ocr_out_stage #(
        .W(ocr_pkg::RATIO_W),
        .INIT(ocr_pkg::DIV_OFFSET)
    ) pairBStage (
        .clk_sys(clk_sys),
        .rst(rst),
        .clkEn(clkEn),
        .d(next_pairBDivRatio),
        .q(pairBDivRatio)
    ); // RL2

    ocr_out_stage #(
        .W(1)
    ) supplyStage (
        .clk_sys(clk_sys),
        .rst(rst),
        .clkEn(clkEn),
        .d(regPairBDrv[ocr_pkg::SUPPLY_BIT]),
        .q(pairBSupplyHigh)
    ); // RL16

    ocr_out_stage #(
        .W($bits(ocr_pkg::ocr_chan_s))
    ) out2Stage (
        .clk_sys(clk_sys),
        .rst(rst),
        .clkEn(clkEn),
        .d(next_out2Cfg),
        .q(out2Cfg)
    );

    ocr_out_stage #(
        .W($bits(ocr_pkg::ocr_chan_s))
    ) out3Stage (
        .clk_sys(clk_sys),
        .rst(rst),
        .clkEn(clkEn),
        .d(next_out3Cfg),
        .q(out3Cfg)
    );

    ocr_out_stage #(
        .W($bits(ocr_pkg::ocr_chan4_s))
    ) out4Stage (
        .clk_sys(clk_sys),
        .rst(rst),
        .clkEn(clkEn),
        .d(next_out4Cfg),
        .q(out4Cfg)
    );

endmodule // ocr_output_channel_config_regs

// One stored word: byte lanes merge in, undefined bits never stick
module ocr_cfg_word #(
    parameter logic [ocr_pkg::REG_W-1:0] FIELDS = '1
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic wrEn,
    input wire logic [ocr_pkg::REG_W-1:0] wrData,
    input wire logic [ocr_pkg::REG_W-1:0] lanes,
    output logic [ocr_pkg::REG_W-1:0] word
);
    logic [ocr_pkg::REG_W-1:0] next_word;
    assign next_word = wrEn ? (((word & ~lanes) | (wrData & lanes)) & FIELDS) :
        word; // RL21

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            word <= ocr_pkg::REG_RESET;
        end else if (clkEn) begin
            word <= next_word;
        end
    end
endmodule // ocr_cfg_word

// Codes 00 and 01 both fall to the low-swing kind
module ocr_drv_code (
    input wire logic [1:0] code,
    output logic [1:0] kind
);
    assign kind = (code == ocr_pkg::DRV_CODE_TOP) ? ocr_pkg::DRV_HIGH_SWING :
        (code == ocr_pkg::DRV_CODE_MID) ? ocr_pkg::DRV_CURRENT_MODE :
        ocr_pkg::DRV_LOW_SWING;
endmodule // ocr_drv_code

// Field 255 divides by 256, hence the extra ratio bit
module ocr_div_ratio (
    input wire logic [ocr_pkg::DIV_W-1:0] field,
    output logic [ocr_pkg::RATIO_W-1:0] ratio
);
    assign ratio = ocr_pkg::RATIO_W'(field) + ocr_pkg::DIV_OFFSET;
endmodule // ocr_div_ratio

// Registered copy of a decoded value, frozen with the rest
module ocr_out_stage #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q <= INIT;
        end else if (clkEn) begin
            q <= d;
        end
    end
endmodule // ocr_out_stage
`default_nettype wire

// ### ocr_pkg.sv
`default_nettype none
package ocr_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    localparam int DIV_W = 8;
    localparam int RATIO_W = DIV_W + 1;

    // Register indices; byte address is the index times four
    localparam logic [ADDR_W-1:0] IDX_PAIR_A_DIV = 12'h006;
    localparam logic [ADDR_W-1:0] IDX_PAIR_B_DRV = 12'h007;
    localparam logic [ADDR_W-1:0] IDX_PAIR_B_DIV = 12'h008;
    localparam logic [ADDR_W-1:0] IDX_OUT4_CTL = 12'h009;
    localparam logic [ADDR_W-1:0] IDX_STATUS = 12'h010;
    localparam int IDX_SHIFT = 2;
    localparam logic [ADDR_W-1:0] ADDR_PAIR_A_DIV = IDX_PAIR_A_DIV << IDX_SHIFT;
    localparam logic [ADDR_W-1:0] ADDR_PAIR_B_DRV = IDX_PAIR_B_DRV << IDX_SHIFT;
    localparam logic [ADDR_W-1:0] ADDR_PAIR_B_DIV = IDX_PAIR_B_DIV << IDX_SHIFT;
    localparam logic [ADDR_W-1:0] ADDR_OUT4_CTL = IDX_OUT4_CTL << IDX_SHIFT;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = IDX_STATUS << IDX_SHIFT;

    // Defined fields per register; reserved bits are never stored
    localparam logic [REG_W-1:0] MASK_PAIR_A_DIV = 16'h00FF;
    localparam logic [REG_W-1:0] MASK_PAIR_B_DRV = 16'h01FF;
    localparam logic [REG_W-1:0] MASK_PAIR_B_DIV = 16'h00FF;
    localparam logic [REG_W-1:0] MASK_OUT4_CTL = 16'h7FDF;
    localparam logic [REG_W-1:0] REG_RESET = 16'h0000;

    localparam int DIV_LSB = 0;
    localparam int SUPPLY_BIT = 0;
    localparam int OUT2_RUN_LSB = 1;
    localparam int OUT2_DRV_LSB = 3;
    localparam int OUT3_RUN_LSB = 5;
    localparam int OUT3_DRV_LSB = 7;
    localparam int OUT4_RUN_LSB = 1;
    localparam int OUT4_DRV_LSB = 3;
    localparam int OUT4_POS_BIT = 6;
    localparam int OUT4_NEG_BIT = 7;
    localparam int OUT4_SLEW_BIT = 8;
    localparam int OUT4_FRAC_BIT = 9;
    localparam int OUT4_PRE_LSB = 10;
    localparam int OUT4_SRC_LSB = 13;

    localparam logic [RATIO_W-1:0] DIV_OFFSET = 9'h001;
    localparam logic [1:0] DRV_CODE_MID = 2'h2;
    localparam logic [1:0] DRV_CODE_TOP = 2'h3;
    localparam logic [1:0] SRC_CODE_PRI = 2'h1;
    localparam logic [1:0] SRC_CODE_SEC = 2'h2;
    localparam logic [2:0] PRE_CODE_DIV2 = 3'h0;
    localparam logic [2:0] PRE_CODE_DIV3 = 3'h1;
    localparam logic [2:0] PRE_CODE_DIV1 = 3'h7;
    localparam logic [1:0] RATIO_ONE = 2'h1;
    localparam logic [1:0] RATIO_TWO = 2'h2;
    localparam logic [1:0] RATIO_THREE = 2'h3;

    typedef enum logic [1:0] {RUN_OFF, RUN_ACTIVE, RUN_STATIC_LOW, RUN_STATIC_HIGH} ocr_run_e;
    typedef enum logic [1:0] {DRV_LOW_SWING, DRV_CURRENT_MODE, DRV_HIGH_SWING} ocr_drv_e;
    typedef enum logic [1:0] {DRV4_LOW_SWING, DRV4_SINGLE_CMOS, DRV4_HOST_CLOCK} ocr_drv4_e;
    typedef enum logic [1:0] {SRC_PLL, SRC_PRIMARY, SRC_SECONDARY} ocr_src_e;

    typedef struct packed {
        ocr_run_e runMode;
        ocr_drv_e driverType;
    } ocr_chan_s;

    typedef struct packed {
        ocr_run_e runMode;
        ocr_drv4_e driverType;
        ocr_src_e source;
        logic fracOn;
        logic [1:0] prescaleRatio;
        logic edgeSlow;
        logic singlePosOn;
        logic singleNegOn;
        logic supplyHigh;
    } ocr_chan4_s;
endpackage
`default_nettype wire

// ### ocr_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ocr_regs_monitor (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic [8:0] pairADivRatio,
    input wire logic [8:0] pairBDivRatio,
    input wire logic pairBSupplyHigh,
    input wire ocr_pkg::ocr_chan_s out3Cfg,
    input wire ocr_pkg::ocr_chan4_s out4Cfg
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [15:0] wd1, wd2;
    wire logic wrDone = psel && penable && pready && pwrite;
    wire logic wrA = wrDone && paddr == ocr_pkg::ADDR_PAIR_A_DIV && pstrb[0];
    wire logic wrB = wrDone && paddr == ocr_pkg::ADDR_PAIR_B_DIV && pstrb[0];
    wire logic wrDrv = wrDone && paddr == ocr_pkg::ADDR_PAIR_B_DRV && pstrb[1:0] == 2'h3;
    wire logic wr4 = wrDone && paddr == ocr_pkg::ADDR_OUT4_CTL && pstrb[1:0] == 2'h3;
    // Data two edges back lines up with the decoded output update
    always_ff @(posedge clk_sys) begin
        wd1 <= pwdata[15:0];
        wd2 <= wd1;
    end
    a_pair_a_ratio: assert property (wrA ##1 clkEn |=> pairADivRatio == 9'(wd2[7:0]) + 9'h001)
        else $error("pair A ratio wrong");
    a_pair_b_ratio: assert property (wrB ##1 clkEn |=> pairBDivRatio == 9'(wd2[7:0]) + 9'h001)
        else $error("pair B ratio wrong");
    a_out3_run: assert property (wrDrv ##1 clkEn |=> out3Cfg.runMode == wd2[6:5])
        else $error("out3 run mode wrong");
    a_out3_drv: assert property (wrDrv ##1 clkEn |=>
        out3Cfg.driverType == (wd2[8] ? (wd2[7] ? 2'h2 : 2'h1) : 2'h0))
        else $error("out3 driver type wrong");
    a_supply_b: assert property (wrDrv ##1 clkEn |=> pairBSupplyHigh == wd2[0])
        else $error("pair B supply wrong");
    a_out4_src: assert property (wr4 ##1 clkEn |=> out4Cfg.source ==
        (wd2[14:13] == 2'h1 ? 2'h1 : (wd2[14:13] == 2'h2 ? 2'h2 : 2'h0)))
        else $error("out4 source wrong");
    a_frac_bit: assert property (wr4 ##1 clkEn |=> out4Cfg.fracOn == wd2[9])
        else $error("out4 frac enable wrong");
    a_neg_gated: assert property (out4Cfg.singleNegOn |-> out4Cfg.singlePosOn)
        else $error("negative side on without positive");
    a_bypass_off: assert property (!$past(rst) && $past(clkEn) && !out4Cfg.fracOn
        |-> out4Cfg.prescaleRatio == ocr_pkg::RATIO_ONE)
        else $error("prescaler not bypassed");
    c_write_a: cover property (wrA);
    c_write_4: cover property (wr4 && pwdata[9]);
    c_frozen: cover property (psel && !clkEn);
endmodule // ocr_regs_monitor
bind ocr_output_channel_config_regs ocr_regs_monitor mon (.clk_sys, .rst, .clkEn, .paddr,
    .psel, .penable, .pwrite, .pwdata, .pstrb, .pready, .pairADivRatio, .pairBDivRatio,
    .pairBSupplyHigh, .out3Cfg, .out4Cfg);
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_sys = 0, rst = 1, clkEn = 1, psel = 0, penable = 0, pwrite = 0, pready;
    logic pslverr, err, pairBSupplyHigh;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [3:0] pstrb = '0;
    logic [8:0] pairADivRatio, pairBDivRatio;
    ocr_pkg::ocr_chan_s out2Cfg, out3Cfg;
    ocr_pkg::ocr_chan4_s out4Cfg;
    logic [15:0] mdl [4];
    int n_errors = 0, checks_done = 0;
    localparam logic [11:0] ADR [4] = '{ocr_pkg::ADDR_PAIR_A_DIV, ocr_pkg::ADDR_PAIR_B_DRV,
        ocr_pkg::ADDR_PAIR_B_DIV, ocr_pkg::ADDR_OUT4_CTL};
    localparam logic [15:0] MSK [4] = '{ocr_pkg::MASK_PAIR_A_DIV, ocr_pkg::MASK_PAIR_B_DRV,
        ocr_pkg::MASK_PAIR_B_DIV, ocr_pkg::MASK_OUT4_CTL};
    ocr_output_channel_config_regs uut (.clk_sys, .rst, .clkEn, .paddr, .psel, .penable,
        .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr, .pairADivRatio, .pairBDivRatio,
        .pairBSupplyHigh, .out2Cfg, .out3Cfg, .out4Cfg);
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic end_of_test();
        if (n_errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    // Idle edge first, so back-to-back calls never drive psel twice in one step
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
            input logic [3:0] s);
        int n;
        @(posedge clk_sys);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        pstrb <= s;
        psel <= 1'b1;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        // Read right after the edge: the values the slave showed at that edge
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            n_errors++;
            $display("[ERR] pready exp 1 got %b", pready);
            end_of_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input int i, input logic [15:0] d, input logic [3:0] s);
        logic [15:0] ln;
        ln = {{8{s[1]}}, {8{s[0]}}};
        apb(ADR[i], 1'b1, {16'h0000, d}, s);
        mdl[i] = (mdl[i] & ~ln) | (d & ln & MSK[i]);
    endtask
    function automatic logic [1:0] drv(input logic [1:0] c);
        return c[1] ? (c[0] ? 2'h2 : 2'h1) : 2'h0;
    endfunction
    function automatic logic [12:0] exp4(input logic [15:0] r);
        logic [1:0] src, pre;
        src = r[14:13] == 2'h1 ? 2'h1 : (r[14:13] == 2'h2 ? 2'h2 : 2'h0);
        pre = !r[9] ? 2'h1 : (r[12:10] == 3'h0 ? 2'h2 : (r[12:10] == 3'h1 ? 2'h3 : 2'h1));
        return {r[2:1], drv(r[4:3]), src, r[9], pre, r[8], r[6], r[7] & r[6], r[0]};
    endfunction
    task automatic chk_all();
        logic [12:0] e4;
        repeat (2) @(posedge clk_sys);
        for (int i = 0; i < 4; i++) begin
            apb(ADR[i], 1'b0, 32'h0, 4'h0);
            chk("readback", {16'h0000, mdl[i]}, rd);
            chk("read slverr", 32'h0, 32'(err));
        end
        e4 = exp4(mdl[3]);
        apb(ocr_pkg::ADDR_STATUS, 1'b0, 32'h0, 4'h0);
        chk("status", 32'(e4[5:4]), rd);
        chk("pairA", 32'(mdl[0][7:0]) + 1, 32'(pairADivRatio));
        chk("pairB", 32'(mdl[2][7:0]) + 1, 32'(pairBDivRatio));
        chk("supplyB", 32'(mdl[1][0]), 32'(pairBSupplyHigh));
        chk("out2", 32'({mdl[1][2:1], drv(mdl[1][4:3])}), 32'(out2Cfg));
        chk("out3", 32'({mdl[1][6:5], drv(mdl[1][8:7])}), 32'(out3Cfg));
        chk("out4", 32'(e4), 32'(out4Cfg));
    endtask
    initial begin
        logic [15:0] d;
        logic [3:0] s;
        void'($urandom(24428));
        for (int i = 0; i < 4; i++) mdl[i] = 16'h0000;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        chk_all();
        for (int k = 0; k < 40; k++) begin
            for (int i = 0; i < 4; i++) begin
                d = k == 0 ? 16'hFFFF : (k == 1 ? 16'h0000 : 16'($urandom));
                s = k < 2 ? 4'h3 : 4'($urandom_range(1, 3));
                if (d[12:10] > 3'h1) d[12:10] = 3'h7;
                d[7] = d[7] & d[6];
                wr(i, d & MSK[i], s);
            end
            chk_all();
        end
        // Unmapped write must error and leave every register alone
        apb(12'h03C, 1'b1, 32'h0000FFFF, 4'hF);
        chk("unmapped err", 32'h1, 32'(err));
        clkEn <= 1'b0;
        fork
            wr(0, 16'h00A5, 4'h1);
            begin
                repeat (4) @(posedge clk_sys);
                chk("frozen ready", 32'h0, 32'(pready));
                clkEn <= 1'b1;
            end
        join
        chk_all();
        end_of_test();
    end
endmodule // tb
`default_nettype wire
